// ==== rtl/tdsc_counter.sv ====
/*
  One wrapping statistics counter with load, gated increment and a
  one-cycle threshold event.
  Assumes increment and load are synchronous to clk.
*/
`timescale 1ns/1ps

`include "tdsc_map.svh"

module tdsc_counter
    import tdsc_pkg::*;
#(
    parameter int          WIDTH     = 32,
    parameter logic [31:0] THRESHOLD = `TDSC_THR_32
)(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Control
    input  wire logic             inc,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    // Status
    output logic      [WIDTH-1:0] count,
    output logic                  hit
);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             hit;
    } tdsc_cnt_state_t;

    tdsc_cnt_state_t state_reg;
    tdsc_cnt_state_t state_next;

    // Load wins, else wrap increment; event only on reaching threshold
    always_comb
    begin
        state_next     = state_reg;
        state_next.hit = 1'b0;
        if (load)
        begin
            state_next.cnt = load_val;
        end
        else if (inc)
        begin
            state_next.cnt = state_reg.cnt + 1'b1;
            state_next.hit = (state_next.cnt == THRESHOLD[WIDTH-1:0]);
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign count = state_reg.cnt;
    assign hit   = state_reg.hit;

endmodule : tdsc_counter

// ==== rtl/tdsc_map.svh ====
/*
  Register offsets, field positions, reset values and thresholds of the
  transmit deferral statistics counters.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef TDSC_MAP_SVH
`define TDSC_MAP_SVH

// Byte offsets in the host register window
`define TDSC_OFS_TX_GOOD        8'hdc
`define TDSC_OFS_DEFER_FIRST    8'he4
`define TDSC_OFS_EXCESS_DEFER   8'he8
`define TDSC_OFS_MASK           8'hec

// Counter reset values
`define TDSC_RST_32             32'h0000_0000
`define TDSC_RST_16             16'h0000

// Threshold values that raise the update event
`define TDSC_THR_32             32'hc000_0000
`define TDSC_THR_16             16'hc000

// Counter mask bit positions
`define TDSC_MSK_DEFER_FIRST    0
`define TDSC_MSK_EXCESS_DEFER   1
`define TDSC_MSK_TX_GOOD        2

`endif

// ==== rtl/tdsc_pkg.sv ====
/*
  Types shared by the transmit deferral statistics counters.
  Assumes the map header is in the include path.
*/
`include "tdsc_map.svh"

package tdsc_pkg;

    // Per-frame transmit outcome from the MAC, one-cycle pulse group
    typedef struct packed {
        logic done;         // Frame finished, outcome fields valid
        logic ok;           // Frame sent successfully
        logic deferred;     // First attempt waited for busy medium
        logic collided;     // Frame took part in a collision
        logic excess_defer; // Deferral exceeded the defer limit
    } tdsc_tx_status_t;

    // Host register access, one-cycle strobes
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } tdsc_host_req_t;

endpackage : tdsc_pkg

// ==== rtl/tdsc_stats.sv ====
/*
  Transmit deferral statistics counter bank: deferred first attempt,
  excessive deferral and transmitted good frames, with host access.
  Assumes a MAC on the same clock giving one status pulse per frame and
  a host port issuing one-cycle whole-word read and write strobes.
*/
`timescale 1ns/1ps

`include "tdsc_map.svh"

// Overview of operation
// - Count each frame whose first attempt waited for a busy medium, 32 bits.
// - Never count a deferred frame that also suffered a collision.
// - Deferred first attempt counter wraps to zero after all ones.
// - Deferred first attempt counter reaching 0xc0000000 raises the update event.
// - Counting needs global enable at one and the counter mask bit at zero.
// - Count each frame whose deferral exceeded the defer limit.
// - Excessive deferral counts at most once per frame.
// - Excessive deferral counter is 16 bits and wraps to zero.
// - Excessive deferral counter reaching 0xc000 raises the update event.
// - Count every frame transmitted successfully, 32 bits.
// - Good frame counter wraps to zero after 0xffffffff.
// - Good frame counter reaching 0xc0000000 raises the update event.
// - Both 32-bit counters hold zero after reset.

module tdsc_stats
    import tdsc_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // MAC transmit outcome
    input  wire tdsc_tx_status_t tx_status,
    // Global enable from the MAC control register
    input  wire logic            counters_global_on,
    // Host register port
    input  wire tdsc_host_req_t  host_req,
    output logic [31:0]          host_rdata,
    output logic                 host_rvalid,
    // Update event toward the interrupt status register
    output logic                 counter_threshold_event
);

    typedef struct packed {
        logic [2:0]  counter_mask;
        logic [31:0] rdata;
        logic        rvalid;
        logic        event_out;
    } tdsc_state_t;

    tdsc_state_t state_reg;
    tdsc_state_t state_next;

    logic [31:0] defer_first_cnt;
    logic [15:0] excess_defer_cnt;
    logic [31:0] tx_good_cnt;
    logic        defer_first_hit;
    logic        excess_defer_hit;
    logic        tx_good_hit;
    logic        defer_first_inc;
    logic        excess_defer_inc;
    logic        tx_good_inc;
    logic        wr_defer_first;
    logic        wr_excess_defer;
    logic        wr_tx_good;

    // Gated increments, one per finished frame
    assign defer_first_inc  = tx_status.done && tx_status.deferred && !tx_status.collided
                              && counters_global_on
                              && !state_reg.counter_mask[`TDSC_MSK_DEFER_FIRST];
    assign excess_defer_inc = tx_status.done && tx_status.excess_defer
                              && counters_global_on
                              && !state_reg.counter_mask[`TDSC_MSK_EXCESS_DEFER];
    assign tx_good_inc      = tx_status.done && tx_status.ok
                              && counters_global_on
                              && !state_reg.counter_mask[`TDSC_MSK_TX_GOOD];

    // Write decode, whole words
    assign wr_defer_first  = host_req.wr && (host_req.addr == `TDSC_OFS_DEFER_FIRST);
    assign wr_excess_defer = host_req.wr && (host_req.addr == `TDSC_OFS_EXCESS_DEFER);
    assign wr_tx_good      = host_req.wr && (host_req.addr == `TDSC_OFS_TX_GOOD);

    // Deferred first attempt counter
    tdsc_counter #(
        .WIDTH     (32),
        .THRESHOLD (`TDSC_THR_32)
    ) u_defer_first (
        .clk      (clk),
        .rst      (rst),
        .inc      (defer_first_inc),
        .load     (wr_defer_first),
        .load_val (host_req.wdata),
        .count    (defer_first_cnt),
        .hit      (defer_first_hit)
    );

    // Excessive deferral counter
    tdsc_counter #(
        .WIDTH     (16),
        .THRESHOLD ({16'h0000, `TDSC_THR_16})
    ) u_excess_defer (
        .clk      (clk),
        .rst      (rst),
        .inc      (excess_defer_inc),
        .load     (wr_excess_defer),
        .load_val (host_req.wdata[15:0]),
        .count    (excess_defer_cnt),
        .hit      (excess_defer_hit)
    );

    // Transmitted good frames counter
    tdsc_counter #(
        .WIDTH     (32),
        .THRESHOLD (`TDSC_THR_32)
    ) u_tx_good (
        .clk      (clk),
        .rst      (rst),
        .inc      (tx_good_inc),
        .load     (wr_tx_good),
        .load_val (host_req.wdata),
        .count    (tx_good_cnt),
        .hit      (tx_good_hit)
    );

    // Mask register, read mux and event output
    always_comb
    begin
        state_next           = state_reg;
        state_next.rvalid    = host_req.rd;
        state_next.event_out = defer_first_hit || excess_defer_hit || tx_good_hit;
        if (host_req.wr && host_req.addr == `TDSC_OFS_MASK)
            state_next.counter_mask = host_req.wdata[2:0];
        if (host_req.rd)
        begin
            case (host_req.addr)
                `TDSC_OFS_DEFER_FIRST:  state_next.rdata = defer_first_cnt;
                `TDSC_OFS_EXCESS_DEFER: state_next.rdata = {16'h0000, excess_defer_cnt};
                `TDSC_OFS_TX_GOOD:      state_next.rdata = tx_good_cnt;
                `TDSC_OFS_MASK:         state_next.rdata = {29'h0000_0000, state_reg.counter_mask};
                default:                state_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign host_rdata              = state_reg.rdata;
    assign host_rvalid             = state_reg.rvalid;
    assign counter_threshold_event = state_reg.event_out;

    // Checks
    defer_collide_a: assert property (@(posedge clk) disable iff (rst)
        tx_status.done && tx_status.collided && !wr_defer_first |=> $stable(defer_first_cnt))
        else $error("deferred counter moved on collided frame");
    defer_count_a: assert property (@(posedge clk) disable iff (rst)
        defer_first_inc && !wr_defer_first |=> defer_first_cnt == $past(defer_first_cnt) + 32'h1)
        else $error("deferred counter missed increment");
    gate_hold_a: assert property (@(posedge clk) disable iff (rst)
        !counters_global_on && !host_req.wr |=> $stable(tx_good_cnt) && $stable(excess_defer_cnt))
        else $error("counter moved while disabled");
    excess_wrap_a: assert property (@(posedge clk) disable iff (rst)
        excess_defer_inc && !wr_excess_defer && excess_defer_cnt == 16'hffff |=> excess_defer_cnt == 16'h0000)
        else $error("excess counter did not wrap");
    good_wrap_a: assert property (@(posedge clk) disable iff (rst)
        tx_good_inc && !wr_tx_good && tx_good_cnt == 32'hffff_ffff |=> tx_good_cnt == 32'h0)
        else $error("good counter did not wrap");
    good_event_a: assert property (@(posedge clk) disable iff (rst)
        tx_good_inc && !wr_tx_good && tx_good_cnt == 32'hbfff_ffff |=> ##1 counter_threshold_event)
        else $error("good threshold event missing");
    excess_event_a: assert property (@(posedge clk) disable iff (rst)
        excess_defer_inc && !wr_excess_defer && excess_defer_cnt == 16'hbfff |=> ##1 counter_threshold_event)
        else $error("excess threshold event missing");
    event_pulse_a: assert property (@(posedge clk) disable iff (rst)
        counter_threshold_event |-> $past(defer_first_inc || excess_defer_inc || tx_good_inc, 2))
        else $error("event without counter increment");
    write_load_a: assert property (@(posedge clk) disable iff (rst)
        wr_tx_good |=> tx_good_cnt == $past(host_req.wdata))
        else $error("write did not load counter");
    reset_zero_a: assert property (@(posedge clk)
        rst |=> defer_first_cnt == 32'h0 && tx_good_cnt == 32'h0)
        else $error("counters not zero after reset");
    reset_state_a: assert property (@(posedge clk)
        rst |=> !host_rvalid && !counter_threshold_event && excess_defer_cnt == 16'h0000 && state_reg.counter_mask == 3'h0)
        else $error("bank state not cleared by reset");

    // Deferred first attempt counter: wrap, threshold and global enable gate
    defer_wrap_a: assert property (@(posedge clk) disable iff (rst)
        defer_first_inc && !wr_defer_first && defer_first_cnt == 32'hffff_ffff |=> defer_first_cnt == 32'h0)
        else $error("deferred counter did not wrap");
    defer_event_a: assert property (@(posedge clk) disable iff (rst)
        defer_first_inc && !wr_defer_first && defer_first_cnt == 32'hbfff_ffff |=> ##1 counter_threshold_event)
        else $error("deferred threshold event missing");
    defer_gate_a: assert property (@(posedge clk) disable iff (rst)
        !counters_global_on && !wr_defer_first |=> $stable(defer_first_cnt))
        else $error("deferred counter moved while disabled");

    // Plain increments of the other two counters
    excess_count_a: assert property (@(posedge clk) disable iff (rst)
        excess_defer_inc && !wr_excess_defer |=> excess_defer_cnt == $past(excess_defer_cnt) + 16'h1)
        else $error("excess counter missed increment");
    good_count_a: assert property (@(posedge clk) disable iff (rst)
        tx_good_inc && !wr_tx_good |=> tx_good_cnt == $past(tx_good_cnt) + 32'h1)
        else $error("good counter missed increment");

    // Mask bits freeze their counter
    defer_mask_a: assert property (@(posedge clk) disable iff (rst)
        state_reg.counter_mask[`TDSC_MSK_DEFER_FIRST] && !wr_defer_first |=> $stable(defer_first_cnt))
        else $error("masked deferred counter moved");
    excess_mask_a: assert property (@(posedge clk) disable iff (rst)
        state_reg.counter_mask[`TDSC_MSK_EXCESS_DEFER] && !wr_excess_defer |=> $stable(excess_defer_cnt))
        else $error("masked excess counter moved");
    good_mask_a: assert property (@(posedge clk) disable iff (rst)
        state_reg.counter_mask[`TDSC_MSK_TX_GOOD] && !wr_tx_good |=> $stable(tx_good_cnt))
        else $error("masked good counter moved");
    mask_write_a: assert property (@(posedge clk) disable iff (rst)
        host_req.wr && host_req.addr == `TDSC_OFS_MASK |=> state_reg.counter_mask == $past(host_req.wdata[2:0]))
        else $error("mask write not taken");

    // Software loads, never raising the event
    defer_load_a: assert property (@(posedge clk) disable iff (rst)
        wr_defer_first |=> defer_first_cnt == $past(host_req.wdata))
        else $error("write did not load deferred counter");
    excess_load_a: assert property (@(posedge clk) disable iff (rst)
        wr_excess_defer |=> excess_defer_cnt == $past(host_req.wdata[15:0]))
        else $error("write did not load excess counter");
    load_quiet_a: assert property (@(posedge clk) disable iff (rst)
        wr_tx_good |=> !tx_good_hit)
        else $error("write raised threshold hit");
    hit_exact_a: assert property (@(posedge clk) disable iff (rst)
        tx_good_inc && !wr_tx_good && tx_good_cnt != 32'hbfff_ffff |=> !tx_good_hit)
        else $error("hit away from threshold");

    // Read path: one-cycle valid, whole words
    read_follow_a: assert property (@(posedge clk) disable iff (rst)
        host_req.rd |=> host_rvalid)
        else $error("read valid missing");
    read_idle_a: assert property (@(posedge clk) disable iff (rst)
        !host_req.rd |=> !host_rvalid)
        else $error("read valid without read");
    read_defer_a: assert property (@(posedge clk) disable iff (rst)
        host_req.rd && host_req.addr == `TDSC_OFS_DEFER_FIRST |=> host_rdata == $past(defer_first_cnt))
        else $error("deferred read data wrong");
    read_excess_a: assert property (@(posedge clk) disable iff (rst)
        host_req.rd && host_req.addr == `TDSC_OFS_EXCESS_DEFER |=> host_rdata == {16'h0000, $past(excess_defer_cnt)})
        else $error("excess read data wrong");
    read_good_a: assert property (@(posedge clk) disable iff (rst)
        host_req.rd && host_req.addr == `TDSC_OFS_TX_GOOD |=> host_rdata == $past(tx_good_cnt))
        else $error("good read data wrong");
    read_unmapped_a: assert property (@(posedge clk) disable iff (rst)
        host_req.rd && !(host_req.addr inside {`TDSC_OFS_DEFER_FIRST, `TDSC_OFS_EXCESS_DEFER,
                                               `TDSC_OFS_TX_GOOD, `TDSC_OFS_MASK}) |=> host_rdata == 32'h0)
        else $error("unmapped read not zero");

    good_seen_c:   cover property (@(posedge clk) disable iff (rst) tx_good_inc);
    defer_seen_c:  cover property (@(posedge clk) disable iff (rst) defer_first_inc);
    event_seen_c:  cover property (@(posedge clk) disable iff (rst) counter_threshold_event);
    wrap_seen_c:   cover property (@(posedge clk) disable iff (rst) tx_good_inc && tx_good_cnt == 32'hffff_ffff);
    masked_seen_c: cover property (@(posedge clk) disable iff (rst)
        tx_status.done && tx_status.ok && counters_global_on && state_reg.counter_mask[`TDSC_MSK_TX_GOOD]);

endmodule : tdsc_stats

// ==== test/tdsc_stats_tb.sv ====
/*
  Self-checking bench for the transmit deferral statistics counter bank.
  Assumes the package and map header are compiled and included first.
*/
`timescale 1ns/1ps

`include "tdsc_map.svh"

module tdsc_stats_tb;
    import tdsc_pkg::*;

    // Design inputs and outputs
    logic            clk                = 1'b0;
    logic            rst                = 1'b1;
    tdsc_tx_status_t tx_status          = '0;
    logic            counters_global_on = 1'b0;
    tdsc_host_req_t  host_req           = '0;
    logic [31:0]     host_rdata;
    logic            host_rvalid;
    logic            counter_threshold_event;
    // Score and model: index 0 deferred, 1 excess, 2 good
    int              err_total  = 0;
    int              num_checks = 0;
    logic [31:0]     m_cnt [3]  = '{32'h0, 32'h0, 32'h0};
    logic [2:0]      m_mask     = 3'h0;
    logic [7:0]      ofs [3]    = '{`TDSC_OFS_DEFER_FIRST, `TDSC_OFS_EXCESS_DEFER, `TDSC_OFS_TX_GOOD};
    tdsc_tx_status_t s;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    tdsc_stats DUT (
        .clk                     (clk),
        .rst                     (rst),
        .tx_status               (tx_status),
        .counters_global_on      (counters_global_on),
        .host_req                (host_req),
        .host_rdata              (host_rdata),
        .host_rvalid             (host_rvalid),
        .counter_threshold_event (counter_threshold_event)
    );

    // Which counter a frame outcome feeds
    function automatic logic feeds(tdsc_tx_status_t f, int i);
        return (i == 0) ? (f.deferred && !f.collided) : (i == 1) ? f.excess_defer : f.ok;
    endfunction : feeds

    // Counter value after one increment, excess is 16 bits wide
    function automatic logic [31:0] bump(logic [31:0] v, int i);
        return (i == 1) ? {16'h0, v[15:0] + 16'h1} : v + 32'h1;
    endfunction : bump

    // Whether a value sits on the counter's threshold
    function automatic logic at_thr(logic [31:0] v, int i);
        return (i == 1) ? (v === {16'h0, `TDSC_THR_16}) : (v === `TDSC_THR_32);
    endfunction : at_thr

    // Comparisons
    task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(string what, logic exp, logic got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    // Host write, model follows at the taking edge
    task automatic reg_wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        host_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        host_req <= '0;
        for (int i = 0; i < 3; i++)
            if (a == ofs[i])
                m_cnt[i] = (i == 1) ? {16'h0, d[15:0]} : d;
        if (a == `TDSC_OFS_MASK)
            m_mask = d[2:0];
    endtask : reg_wr

    // Host read, answer checked just after the taking edge
    task automatic reg_rd(logic [7:0] a, logic [31:0] exp);
        @(posedge clk);
        host_req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk);
        host_req <= '0;
        #1;
        chk_bit("rvalid", 1'b1, host_rvalid);
        chk_word("rdata", exp, host_rdata);
    endtask : reg_rd

    task automatic chk_all();
        for (int i = 0; i < 3; i++)
            reg_rd(ofs[i], m_cnt[i]);
        reg_rd(`TDSC_OFS_MASK, {29'h0, m_mask});
    endtask : chk_all

    // One frame outcome pulse, event checked one cycle after it is taken
    task automatic frame(tdsc_tx_status_t f, logic on);
        logic ev;
        ev = 1'b0;
        @(posedge clk);
        tx_status <= f;
        counters_global_on <= on;
        @(posedge clk);
        tx_status <= '0;
        for (int i = 0; i < 3; i++)
            if (on && !m_mask[i] && feeds(f, i))
            begin
                m_cnt[i] = bump(m_cnt[i], i);
                ev |= at_thr(m_cnt[i], i);
            end
        @(posedge clk);
        #1;
        chk_bit("event", ev, counter_threshold_event);
        chk_bit("rvalid idle", 1'b0, host_rvalid);
    endtask : frame

    task automatic give_verdict();
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    // Main sequence
    initial
    begin
        void'($urandom(32'h0d72));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        chk_all();
        reg_rd(8'hf0, 32'h0);
        // Threshold, no repeat above it, then wrap, for each counter
        for (int i = 0; i < 3; i++)
        begin
            s = '{1'b1, i == 2, i == 0, 1'b0, i == 1};
            reg_wr(ofs[i], (i == 1) ? 32'hbfff : 32'hbfffffff);
            frame(s, 1'b1);
            frame(s, 1'b1);
            reg_wr(ofs[i], (i == 1) ? 32'hffff : 32'hffffffff);
            frame(s, 1'b1);
        end
        chk_all();
        frame('{1'b1, 1'b0, 1'b1, 1'b1, 1'b0}, 1'b1);
        reg_wr(`TDSC_OFS_MASK, 32'h7);
        frame('{1'b1, 1'b1, 1'b1, 1'b0, 1'b1}, 1'b1);
        reg_wr(`TDSC_OFS_MASK, 32'h0);
        frame('{1'b1, 1'b1, 1'b1, 1'b0, 1'b1}, 1'b0);
        reg_wr(8'hf0, 32'h1234_5678);
        chk_all();
        // Random outcomes, enables and masks
        repeat (200)
        begin
            s = tdsc_tx_status_t'(5'($urandom));
            s.done = 1'b1;
            if ($urandom_range(0, 9) == 0)
                reg_wr(`TDSC_OFS_MASK, $urandom_range(0, 7));
            frame(s, $urandom_range(0, 3) != 0);
        end
        chk_all();
        give_verdict();
    end

    // Watchdog against a hang
    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        give_verdict();
    end

endmodule : tdsc_stats_tb
